// ===== design/thermal_replica_overload.sv
// thermal replica overload decision logic with ahb-lite settings
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module thermal_replica_overload (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// measurement and binary inputs
	input  wire logic [15:0] i_irms_l1,
	input  wire logic [15:0] i_irms_l2,
	input  wire logic [15:0] i_irms_l3,
	input  wire logic [7:0]  i_sensor_temp,
	input  wire logic        i_disable_in,
	input  wire logic        i_heat_reset_in,
	// status outputs
	output logic             o_alarm_out,
	output logic             o_general_trip_out,
	output logic             o_reclose_block_out,
	output logic      [15:0] o_calc_temp_value
);
	import thermal_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// clamp a written setting into its legal range
	function automatic logic [9:0] clamp(input logic [9:0] v,
		input logic [9:0] lo, input logic [9:0] hi);
		if (v < lo)
			clamp = lo;
		else if (v > hi)
			clamp = hi;
		else
			clamp = v;
	endfunction

	function automatic logic [15:0] max2(input logic [15:0] a,
		input logic [15:0] b);
		max2 = (a > b) ? a : b;
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [1:0]  dis_sync_r;
	logic [1:0]  rst_sync_r;
	logic [15:0] irms_s1_r [3];
	logic [15:0] irms_s2_r [3];
	logic [7:0]  sens_s1_r;
	logic [7:0]  sens_s2_r;
	logic [15:0] irms_in [3];

	assign irms_in[0] = i_irms_l1;
	assign irms_in[1] = i_irms_l2;
	assign irms_in[2] = i_irms_l3;

	// binary inputs come from outside logic, two stages each
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dis_sync_r <= 2'h0;
			rst_sync_r <= 2'h0;
			sens_s1_r  <= 8'h00;
			sens_s2_r  <= 8'h00;
		end else begin
			dis_sync_r <= {dis_sync_r[0], i_disable_in};
			rst_sync_r <= {rst_sync_r[0], i_heat_reset_in};
			sens_s1_r  <= i_sensor_temp;
			sens_s2_r  <= sens_s1_r;
		end
	end

	// measured values are slow; two stages suffice between updates
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					irms_s1_r[g] <= 16'h0000;
					irms_s2_r[g] <= 16'h0000;
				end else begin
					irms_s1_r[g] <= irms_in[g];
					irms_s2_r[g] <= irms_s1_r[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// settings registers
	// ----------------------------------------------------------------
	logic [1:0] mode_r;
	logic       sens_sel_r;
	logic       sw_dis_r;
	logic       sw_rst_r;
	logic [7:0] alarm_r, trip_r, rated_r, unlock_r;
	logic [7:0] base_r, amb_r, start_r, inom_r;
	logic [9:0] tau_r;

	// bus address phase capture
	logic       wr_pend_r;
	logic       rd_pend_r;
	logic [7:0] addr_r;
	logic       take;

	assign take      = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;    // zero wait states
	assign hresp     = 1'b0;    // always okay

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h00;
		end else begin
			wr_pend_r <= take && hwrite;
			rd_pend_r <= take && !hwrite;
			if (take)
				addr_r <= {haddr[7:2], 2'b00};
		end
	end

	// data phase write; out of range values are clamped, except a mode of 3, which is dropped
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_r     <= MODE_DEF;
			sens_sel_r <= 1'b0;
			sw_dis_r   <= 1'b0;
			sw_rst_r   <= 1'b0;
			alarm_r    <= ALARM_DEF;
			trip_r     <= TRIP_DEF;
			rated_r    <= RATED_DEF;
			unlock_r   <= UNLOCK_DEF;
			base_r     <= BASE_DEF;
			amb_r      <= AMB_DEF;
			start_r    <= START_DEF;
			inom_r     <= INOM_DEF;
			tau_r      <= TAU_DEF;
		end else if (wr_pend_r) begin
			case (addr_r)
			CTRL_OFS: begin
				mode_r     <= (hwdata[MODE_LSB+:2] == 2'h3) ?
					mode_r : hwdata[MODE_LSB+:2];
				sens_sel_r <= hwdata[SENS_BIT];
				sw_dis_r   <= hwdata[DIS_BIT];
				sw_rst_r   <= hwdata[RST_BIT];
			end
			TEMPS_OFS: begin
				alarm_r  <= 8'(clamp({2'b0, hwdata[ALARM_LSB+:8]},
					{2'b0, TEMP_MIN}, {2'b0, TEMP_MAX}));
				trip_r   <= 8'(clamp({2'b0, hwdata[TRIP_LSB+:8]},
					{2'b0, TEMP_MIN}, {2'b0, TEMP_MAX}));
				rated_r  <= 8'(clamp({2'b0, hwdata[RATED_LSB+:8]},
					{2'b0, TEMP_MIN}, {2'b0, TEMP_MAX}));
				unlock_r <= 8'(clamp({2'b0, hwdata[UNLOCK_LSB+:8]},
					{2'b0, UNL_MIN}, {2'b0, TEMP_MAX}));
			end
			LIMITS_OFS: begin
				base_r  <= 8'(clamp({2'b0, hwdata[BASE_LSB+:8]},
					10'h000, {2'b0, AMB_MAX}));
				amb_r   <= 8'(clamp({2'b0, hwdata[AMB_LSB+:8]},
					10'h000, {2'b0, AMB_MAX}));
				start_r <= 8'(clamp({2'b0, hwdata[START_LSB+:8]},
					10'h000, {2'b0, START_MAX}));
			end
			MODEL_OFS: begin
				inom_r <= 8'(clamp({2'b0, hwdata[INOM_LSB+:8]},
					{2'b0, INOM_MIN}, {2'b0, INOM_MAX}));
				tau_r  <= clamp(hwdata[TAU_LSB+:10],
					TAU_MIN, TAU_MAX);
			end
			default: begin
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// step timer and thermal model
	// ----------------------------------------------------------------
	logic [16:0] step_cnt_r;
	logic        step;
	logic [15:0] imax;
	logic [31:0] level_r;
	logic [31:0] level_nxt;
	logic [7:0]  ambient;
	logic        disabled;
	logic        heat_rst;
	logic [31:0] start_level;

	assign step     = (step_cnt_r == 17'(STEP_CYCLES - 1));
	assign imax     = max2(max2(irms_s2_r[0], irms_s2_r[1]),
		irms_s2_r[2]);
	assign ambient  = sens_sel_r ? sens_s2_r : amb_r;
	assign disabled = dis_sync_r[1] || sw_dis_r;
	assign heat_rst = rst_sync_r[1] || sw_rst_r;
	// startup term is the starting rise in percent of rated rise
	assign start_level = 32'((64'(start_r) << FRAC) / 64'd100);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			step_cnt_r <= 17'h00000;
		else if (step)
			step_cnt_r <= 17'h00000;
		else
			step_cnt_r <= step_cnt_r + 17'h00001;
	end

	thermal_step u_step (
		.i_level (level_r),
		.i_irms  (imax),
		.i_inom  (inom_r),
		.i_tau   (tau_r),
		.o_level (level_nxt)
	);

	// one model update per 1 ms sample period
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			level_r <= 32'h0000_0000;
		else if (heat_rst)
			level_r <= start_level;
		else if (step)
			level_r <= level_nxt;
	end

	// ----------------------------------------------------------------
	// temperature in degrees, q8.8
	// ----------------------------------------------------------------
	logic [47:0] rise;
	logic [15:0] temp_now;
	logic [15:0] rated_rise;

	// level 1.0 means rated temperature above the base reference
	assign rated_rise = (rated_r > base_r) ?
		16'(rated_r - base_r) : 16'h0000;
	assign rise       = (48'(level_r) * 48'(rated_rise)) >> (FRAC - 8);
	assign temp_now   = 16'(rise) + {ambient, 8'h00};

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_calc_temp_value <= 16'h0000;
		else
			o_calc_temp_value <= temp_now;
	end

	// ----------------------------------------------------------------
	// decision logic
	// ----------------------------------------------------------------
	logic        above_trip, above_alarm, below_unlock;
	logic        above_trip_d_r;
	logic        lock_r;
	logic [21:0] pulse_cnt_r;

	// compared once per step on the registered temperature
	assign above_trip   = o_calc_temp_value > {trip_r, 8'h00};
	assign above_alarm  = o_calc_temp_value > {alarm_r, 8'h00};
	assign below_unlock = o_calc_temp_value < {unlock_r, 8'h00};

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			above_trip_d_r <= 1'b0;
			lock_r         <= 1'b0;
			pulse_cnt_r    <= 22'h000000;
		end else if (disabled || mode_r == MODE_OFF) begin
			above_trip_d_r <= 1'b0;
			lock_r         <= 1'b0;
			pulse_cnt_r    <= 22'h000000;
		end else if (step) begin
			above_trip_d_r <= above_trip;
			if (mode_r == MODE_LOCKED) begin
				if (above_trip)
					lock_r <= 1'b1;
				else if (below_unlock)
					lock_r <= 1'b0;
			end else
				lock_r <= 1'b0;
			// fixed width pulse on the rising crossing
			if (mode_r == MODE_PULSED && above_trip && !above_trip_d_r)
				pulse_cnt_r <= 22'(PULSE_CYCLES);
			else if (pulse_cnt_r != 22'h000000)
				pulse_cnt_r <= pulse_cnt_r - 22'h000001;
		end else if (pulse_cnt_r != 22'h000000)
			pulse_cnt_r <= pulse_cnt_r - 22'h000001;
	end

	logic alarm_r_q;
	logic active;
	assign active = !disabled && (mode_r != MODE_OFF);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			alarm_r_q <= 1'b0;
		else if (!active)
			alarm_r_q <= 1'b0;
		else if (step)
			alarm_r_q <= above_alarm;
	end

	// pulse length follows the 20 ms timing tolerance
	assign o_general_trip_out  = active &&
		(lock_r || pulse_cnt_r != 22'h000000);
	assign o_reclose_block_out = o_general_trip_out;
	assign o_alarm_out         = alarm_r_q;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite) begin
			case ({haddr[7:2], 2'b00})
			CTRL_OFS:    hrdata <= {27'h0, sw_rst_r, sw_dis_r,
				sens_sel_r, mode_r};
			TEMPS_OFS:   hrdata <= {unlock_r, rated_r, trip_r, alarm_r};
			LIMITS_OFS:  hrdata <= {8'h00, start_r, amb_r, base_r};
			MODEL_OFS:   hrdata <= {6'h00, tau_r, 8'h00, inom_r};
			CURRENT_OFS: hrdata <= {16'h0000, imax};
			SENSOR_OFS:  hrdata <= {24'h000000, sens_s2_r};
			STATUS_OFS:  hrdata <= {13'h0, o_reclose_block_out,
				o_general_trip_out, o_alarm_out, o_calc_temp_value};
			LEVEL_OFS:   hrdata <= level_r;
			default:     hrdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// ===== design/thermal_pkg.sv
// shared constants for the thermal replica overload block
package thermal_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses on the ahb-lite slave)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] TEMPS_OFS    = 8'h04;
	localparam logic [7:0] LIMITS_OFS   = 8'h08;
	localparam logic [7:0] MODEL_OFS    = 8'h0c;
	localparam logic [7:0] CURRENT_OFS  = 8'h10;
	localparam logic [7:0] SENSOR_OFS   = 8'h14;
	localparam logic [7:0] STATUS_OFS   = 8'h18;
	localparam logic [7:0] LEVEL_OFS    = 8'h1c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MODE_LSB      = 0;   // ctrl[1:0]
	localparam int SENS_BIT      = 2;   // ctrl[2]
	localparam int DIS_BIT       = 3;   // ctrl[3]
	localparam int RST_BIT       = 4;   // ctrl[4]
	localparam int ALARM_LSB     = 0;   // temps[7:0]
	localparam int TRIP_LSB      = 8;   // temps[15:8]
	localparam int RATED_LSB     = 16;  // temps[23:16]
	localparam int UNLOCK_LSB    = 24;  // temps[31:24]
	localparam int BASE_LSB      = 0;   // limits[7:0]
	localparam int AMB_LSB       = 8;   // limits[15:8]
	localparam int START_LSB     = 16;  // limits[23:16]
	localparam int INOM_LSB      = 0;   // model[7:0]
	localparam int TAU_LSB       = 16;  // model[25:16]

	// ----------------------------------------------------------------
	// reset values of the settings
	// ----------------------------------------------------------------
	localparam logic [7:0] ALARM_DEF  = 8'h50;  // 80 deg
	localparam logic [7:0] TRIP_DEF   = 8'h64;  // 100 deg
	localparam logic [7:0] RATED_DEF  = 8'h64;  // 100 deg
	localparam logic [7:0] UNLOCK_DEF = 8'h3c;  // 60 deg
	localparam logic [7:0] BASE_DEF   = 8'h19;  // 25 deg
	localparam logic [7:0] AMB_DEF    = 8'h19;  // 25 deg
	localparam logic [7:0] START_DEF  = 8'h00;
	localparam logic [7:0] INOM_DEF   = 8'h64;  // 100 percent
	localparam logic [9:0] TAU_DEF    = 10'h00a; // 10 min

	// setting ranges
	localparam logic [7:0] TEMP_MIN   = 8'h3c;  // 60
	localparam logic [7:0] TEMP_MAX   = 8'hc8;  // 200
	localparam logic [7:0] UNL_MIN    = 8'h14;  // 20
	localparam logic [7:0] AMB_MAX    = 8'h28;  // 40
	localparam logic [7:0] START_MAX  = 8'h3c;  // 60
	localparam logic [7:0] INOM_MIN   = 8'h14;  // 20
	localparam logic [7:0] INOM_MAX   = 8'h96;  // 150
	localparam logic [9:0] TAU_MIN    = 10'h001;
	localparam logic [9:0] TAU_MAX    = 10'h3e7; // 999

	// ----------------------------------------------------------------
	// timing: one model step per 1 kHz sample
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 100_000_000;
	localparam int SAMPLE_HZ   = 1_000;
	localparam int STEP_CYCLES = CLK_HZ / SAMPLE_HZ;
	localparam int STEPS_PER_MIN = SAMPLE_HZ * 60;
	localparam int TRIP_PULSE_MS = 20;
	localparam int PULSE_CYCLES  = TRIP_PULSE_MS * (CLK_HZ / 1000);

	// fixed point: thermal level h in q8.24
	localparam int FRAC = 24;

	// operating modes
	typedef enum logic [1:0] {
		MODE_OFF, MODE_PULSED, MODE_LOCKED
	} oper_mode_t;
	localparam logic [1:0] MODE_DEF = 2'h1;

endpackage

// ===== design/thermal_step.sv
// one step of the first order heating recursion
`timescale 1ns/1ps
module thermal_step (
	input  wire logic [31:0] i_level,
	input  wire logic [15:0] i_irms,
	input  wire logic [7:0]  i_inom,
	input  wire logic [9:0]  i_tau,
	output logic      [31:0] o_level
);
	import thermal_pkg::*;

	logic [63:0] ratio_sq;
	logic [63:0] decay;
	logic [31:0] alpha;   // dt / tau in q0.32
	logic [15:0] ratio;   // irms / inom in q8.8
	logic [63:0] heat;

	// irms arrives in percent of line rating; ratio is q8.8
	always_comb begin
		ratio    = 16'((32'(i_irms) << 8) / 32'(i_inom));
		ratio_sq = 64'(ratio) * 64'(ratio);            // q16.16
		alpha    = 32'(64'h1_0000_0000 /
			(64'(i_tau) * 64'(STEPS_PER_MIN)));
		// new = level - alpha*level + alpha*ratio^2
		decay    = (64'(i_level) * 64'(alpha)) >> 32;
		heat     = ((ratio_sq << (FRAC - 16)) * 64'(alpha)) >> 32;
		o_level  = 32'(64'(i_level) - decay + heat);
	end

endmodule

// ===== test/thermal_replica_overload_checker.sv
// port-level assertions for the thermal replica overload block
`timescale 1ns/1ps
module thermal_replica_overload_checker
	import thermal_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rstn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        i_disable_in,
	input wire logic        o_alarm_out,
	input wire logic        o_general_trip_out,
	input wire logic        o_reclose_block_out,
	input wire logic [15:0] o_calc_temp_value
);
	logic        addr_ph;
	logic        wr_ctrl_q;
	logic [1:0]  mode_q;
	logic [18:0] status_w;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// an accepted address phase and the status word as the bus shows it
	assign addr_ph  = hsel && hready && htrans[1];
	assign status_w = {o_reclose_block_out, o_general_trip_out, o_alarm_out,
		o_calc_temp_value};

	// shadow of the mode field; a write of 3 is dropped, as in the block
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ctrl_q <= 1'b0;
			mode_q    <= MODE_DEF;
		end else begin
			wr_ctrl_q <= addr_ph && hwrite && haddr[7:0] == CTRL_OFS;
			if (wr_ctrl_q && hwdata[1:0] != 2'h3)
				mode_q <= hwdata[1:0];
		end
	end

	sequence s_rd(logic [7:0] a);
		addr_ph && !hwrite && haddr[7:0] == a;
	endsequence

	// trip is never raised below 60 deg, the lowest trip setting
	property p_trip_hot;
		$rose(o_general_trip_out) |-> ##[0:2] o_calc_temp_value > 16'h3c00;
	endproperty
	property p_alarm_hot;
		$rose(o_alarm_out) |-> ##[0:2] o_calc_temp_value > 16'h3c00;
	endproperty
	property p_block_trip;
		o_reclose_block_out == o_general_trip_out;
	endproperty
	property p_disable;
		i_disable_in [*5] |-> !o_general_trip_out && !o_alarm_out;
	endproperty
	property p_off;
		mode_q == 2'h0 [*3] |-> !o_general_trip_out && !o_alarm_out;
	endproperty
	property p_ctrl_read;
		s_rd(CTRL_OFS) |=> hrdata[1:0] == $past(mode_q);
	endproperty
	property p_status_read;
		s_rd(STATUS_OFS) |=> hrdata[18:0] == $past(status_w);
	endproperty
	property p_bus_ready;
		hreadyout && !hresp;
	endproperty

	a_trip_hot: assert property (p_trip_hot)
		else $error("trip rose at a low temperature");
	a_alarm_hot: assert property (p_alarm_hot)
		else $error("alarm rose at a low temperature");
	a_block_trip: assert property (p_block_trip)
		else $error("reclose block differs from trip");
	a_disable: assert property (p_disable)
		else $error("output active while disabled");
	a_off: assert property (p_off)
		else $error("output active in off mode");
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("mode field read back wrong");
	a_status_read: assert property (p_status_read)
		else $error("status word differs from outputs");
	a_bus_ready: assert property (p_bus_ready)
		else $error("bus stalled or answered with error");
endmodule

bind thermal_replica_overload thermal_replica_overload_checker
	thermal_replica_overload_checker_inst (.i_clk(i_clk), .i_rstn(i_rstn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .i_disable_in(i_disable_in), .o_alarm_out(o_alarm_out),
	.o_general_trip_out(o_general_trip_out),
	.o_reclose_block_out(o_reclose_block_out),
	.o_calc_temp_value(o_calc_temp_value));

// ===== test/relay_logic_model.sv
// far side: relay logic feeding phase rms values and binary inputs
`timescale 1ns/1ps
module relay_logic_model (
	input  wire logic        i_clk,
	output logic      [15:0] o_irms_l1,
	output logic      [15:0] o_irms_l2,
	output logic      [15:0] o_irms_l3,
	output logic      [7:0]  o_sensor_temp,
	output logic             o_disable_in,
	output logic             o_heat_reset_in
);
	// quiet line at power up
	initial begin
		o_irms_l1       = 16'h0000;
		o_irms_l2       = 16'h0000;
		o_irms_l3       = 16'h0000;
		o_sensor_temp   = 8'h00;
		o_disable_in    = 1'b0;
		o_heat_reset_in = 1'b0;
	end

	// new rms results land on a clock edge and then stand as levels
	task automatic set_inputs(input logic [15:0] a, b, c, input logic [7:0] t);
		@(posedge i_clk);
		o_irms_l1     <= a;
		o_irms_l2     <= b;
		o_irms_l3     <= c;
		o_sensor_temp <= t;
	endtask

	task automatic set_disable(input logic v);
		@(posedge i_clk);
		o_disable_in <= v;
	endtask

	// heat reset is a test-only pulse, held a few edges to be seen
	task automatic heat_reset();
		@(posedge i_clk);
		o_heat_reset_in <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_heat_reset_in <= 1'b0;
	endtask
endmodule

// ===== test/testbench.sv
// self-checking bench for the thermal replica overload block
`timescale 1ns/1ps
module testbench;
	import thermal_pkg::*;
	typedef struct {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	logic        i_clk, i_rstn, hsel, hwrite, hready, hreadyout, hresp;
	logic        dis, hrst, o_alarm_out, o_general_trip_out;
	logic        o_reclose_block_out;
	logic [1:0]  htrans;
	logic [2:0]  hsize, flags;
	logic [7:0]  sens;
	logic [15:0] l1, l2, l3, o_calc_temp_value;
	logic [31:0] haddr, hwdata, hrdata;
	int          bad_count, compares;
	// reset values first, then clamping, bad mode, unmapped, test setup
	row_t rows [15] = '{
		'{1'b0, CTRL_OFS,   32'h0,        32'h00000001},
		'{1'b0, TEMPS_OFS,  32'h0,        32'h3c646450},
		'{1'b0, LIMITS_OFS, 32'h0,        32'h00001919},
		'{1'b0, MODEL_OFS,  32'h0,        32'h000a0064},
		'{1'b0, STATUS_OFS, 32'h0,        32'h00001900},
		'{1'b0, LEVEL_OFS,  32'h0,        32'h00000000},
		'{1'b1, TEMPS_OFS,  32'h0aff640a, 32'h14c8643c},
		'{1'b1, LIMITS_OFS, 32'h00ffffff, 32'h003c2828},
		'{1'b1, MODEL_OFS,  32'h00000000, 32'h00010014},
		'{1'b1, MODEL_OFS,  32'h03ff00ff, 32'h03e70096},
		'{1'b1, CTRL_OFS,   32'h00000003, 32'h00000001},
		'{1'b1, 8'h20,      32'hffffffff, 32'h00000000},
		'{1'b1, TEMPS_OFS,  32'h3e64413c, 32'h3e64413c},
		'{1'b1, LIMITS_OFS, 32'h003c1919, 32'h003c1919},
		'{1'b1, MODEL_OFS,  32'h000a0064, 32'h000a0064}
	};

	assign hready = hreadyout;
	assign flags  = {o_reclose_block_out, o_general_trip_out, o_alarm_out};

	thermal_replica_overload thermal_replica_overload_inst (
		.i_clk(i_clk), .i_rstn(i_rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .i_irms_l1(l1), .i_irms_l2(l2), .i_irms_l3(l3),
		.i_sensor_temp(sens), .i_disable_in(dis), .i_heat_reset_in(hrst),
		.o_alarm_out(o_alarm_out), .o_general_trip_out(o_general_trip_out),
		.o_reclose_block_out(o_reclose_block_out),
		.o_calc_temp_value(o_calc_temp_value));

	relay_logic_model relay_logic_model_inst (
		.i_clk(i_clk), .o_irms_l1(l1), .o_irms_l2(l2), .o_irms_l3(l3),
		.o_sensor_temp(sens), .o_disable_in(dis), .o_heat_reset_in(hrst));

	// 100 mhz clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one deg of slack covers the fixed point rounding of the level
	task automatic check_temp(input logic [15:0] e);
		check({31'h0, o_calc_temp_value + 16'h100 >= e &&
			o_calc_temp_value <= e + 16'h100}, 32'h1);
	endtask

	// single ahb-lite transfer, held until hready is seen high each phase
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge i_clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	// trip moves only on a 1 ms step, so allow two steps
	task automatic wait_trip(input logic v);
		int n;
		n = 0;
		while (o_general_trip_out !== v && n < 210000) begin
			@(posedge i_clk);
			n++;
		end
		repeat (2) @(posedge i_clk);
		check({31'h0, o_general_trip_out}, {31'h0, v});
	endtask

	task automatic give_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// about five model steps are needed, so allow eight
	initial begin
		repeat (800000) @(posedge i_clk);
		bad_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		give_verdict();
	end

	initial begin
		logic [31:0] rd;
		i_rstn = 1'b0;
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0, rd);
			check(rd, rows[i].e);
		end
		relay_logic_model_inst.set_inputs(16'h000a, 16'h0082, 16'h0032, 8'h1e);
		repeat (4) @(posedge i_clk);
		bus(1'b0, CURRENT_OFS, 32'h0, rd);
		check(rd, 32'h00000082);
		bus(1'b0, SENSOR_OFS, 32'h0, rd);
		check(rd, 32'h0000001e);
		// sensor ambient of 30 deg lifts the start point from 70 to 75 deg
		wr(CTRL_OFS, 32'h5);
		relay_logic_model_inst.heat_reset();
		repeat (3) @(posedge i_clk);
		check_temp(16'h4b00);
		wait_trip(1'b1);
		check_temp(16'h4b00);
		check({30'h0, o_reclose_block_out, o_alarm_out}, 32'h3);
		wr(CTRL_OFS, 32'h4);
		repeat (3) @(posedge i_clk);
		check({29'h0, flags}, 32'h0);
		wr(CTRL_OFS, 32'h2);
		wait_trip(1'b1);
		// software disable bit clears the lock like the pin does
		wr(CTRL_OFS, 32'ha);
		repeat (3) @(posedge i_clk);
		check({29'h0, flags}, 32'h0);
		wr(CTRL_OFS, 32'h2);
		relay_logic_model_inst.set_disable(1'b1);
		repeat (6) @(posedge i_clk);
		check({29'h0, flags}, 32'h0);
		relay_logic_model_inst.set_disable(1'b0);
		wait_trip(1'b1);
		// 62.5 deg sits between unlock and trip, so the lock must hold
		wr(TEMPS_OFS, 32'h3764413c);
		wr(LIMITS_OFS, 32'h00321919);
		relay_logic_model_inst.heat_reset();
		repeat (3) @(posedge i_clk);
		check_temp(16'h3e80);
		repeat (100010) @(posedge i_clk);
		check({29'h0, flags}, 32'h7);
		// one or two steps at 1.69 times rated add about 0x21 each
		bus(1'b0, LEVEL_OFS, 32'h0, rd);
		check({31'h0, rd > 32'h00800000 &&
			rd <= 32'h00800048}, 32'h1);
		// 47.5 deg is below unlock and alarm; software heat reset here
		wr(LIMITS_OFS, 32'h001e1919);
		wr(CTRL_OFS, 32'h12);
		wr(CTRL_OFS, 32'h2);
		repeat (2) @(posedge i_clk);
		check_temp(16'h2f80);
		wait_trip(1'b0);
		check({31'h0, o_alarm_out}, 32'h0);
		// reset in mid-run clears outputs and restores the settings
		i_rstn <= 1'b0;
		repeat (3) @(posedge i_clk);
		check({13'h0, flags, o_calc_temp_value}, 32'h0);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clk);
		check({16'h0, o_calc_temp_value}, 32'h00001900);
		bus(1'b0, TEMPS_OFS, 32'h0, rd);
		check(rd, 32'h3c646450);
		give_verdict();
	end
endmodule
